// *** core/pwr_pkg.sv ***
// constants, types and helpers shared by the power-mode clock controller
`default_nettype none
package pwr_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] OFF_SYS_ONE = 8'h00;
  localparam logic [7:0] OFF_SYS_TWO = 8'h04;
  localparam logic [7:0] OFF_TIMER_A = 8'h08;
  localparam logic [7:0] OFF_GATE_ONE = 8'h0c;
  localparam logic [7:0] OFF_GATE_TWO = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // field positions in system_control_one
  localparam int STANDBY_BIT = 7;
  localparam int WAIT_SEL_LSB = 4;
  localparam int LOW_SPEED_BIT = 3;
  // field positions in system_control_two
  localparam int DIRECT_BIT = 3;
  localparam int MEDIUM_BIT = 2;
  // field position in timer_a_mode_register
  localparam int WATCH_SEL_BIT = 3;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] GATE_RESET = 8'hff;
  // gated module counts: first gate register then second
  localparam int GATE_ONE_USED = 7;
  localparam int GATE_TWO_USED = 4;
  localparam int N_GATED = 11;
  // state counts of a direct transfer
  localparam logic [15:0] SLEEP_STATES = 16'h0002;
  localparam logic [15:0] INTERNAL_STATES = 16'h0001;
  localparam logic [15:0] EXC_STATES = 16'h000e;
  localparam logic [15:0] PRE_STATES = SLEEP_STATES + INTERNAL_STATES;
  localparam logic [15:0] WATCH_PASS_STATES = 16'h0001;
  // ref_clk cycles per state in each mode (ref_clk stands for the oscillator)
  localparam logic [15:0] HIGH_DIV = 16'h0002;
  localparam logic [15:0] MED_DIV = 16'h0010;
  localparam logic [15:0] SUB_DIV = 16'h0040;
  // program-executing modes
  typedef enum logic [1:0] {
    MODE_HIGH = 2'h0,
    MODE_MED = 2'h1,
    MODE_SUB = 2'h2
  } mode_type;
  // controller states, one-hot
  typedef enum logic [7:0] {
    ST_HIGH = 8'h01,
    ST_MED = 8'h02,
    ST_SUB = 8'h04,
    ST_PRE = 8'h08,
    ST_WATCH = 8'h10,
    ST_EXC = 8'h20,
    ST_SLEEP_HALT = 8'h40,
    ST_WATCH_HALT = 8'h80
  } state_type;
  // cycles of ref_clk per state of the given mode
  function automatic logic [15:0] div_of(input mode_type m);
    case (m)
      MODE_HIGH: div_of = HIGH_DIV;
      MODE_MED: div_of = MED_DIV;
      MODE_SUB: div_of = SUB_DIV;
      default: div_of = HIGH_DIV;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** core/ctrl_if.sv ***
// register fields and status passed between the controller's modules
`default_nettype none
interface ctrl_if;
  logic standby_select;
  logic low_speed_on;
  logic [2:0] standby_wait_select;
  logic medium_speed_on;
  logic direct_transfer_on;
  logic watch_timer_select;
  logic [7:0] module_clock_gate_one;
  logic [7:0] module_clock_gate_two;
  logic [9:0] status;
  // register file drives the fields, reads status
  modport regs (
    output standby_select, low_speed_on, standby_wait_select, medium_speed_on,
    output direct_transfer_on, watch_timer_select,
    output module_clock_gate_one, module_clock_gate_two,
    input status
  );
  // mode controller reads the fields, drives status
  modport core (
    input standby_select, low_speed_on, standby_wait_select, medium_speed_on,
    input direct_transfer_on, watch_timer_select,
    output status
  );
  // gate bank reads the gate registers
  modport gates (
    input module_clock_gate_one, module_clock_gate_two
  );
endinterface
`default_nettype wire

// *** core/apb_regs.sv ***
// apb slave holding the control and clock stop registers
`default_nettype none
module apb_regs
  import pwr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register fields
  ctrl_if.regs cif
);
  logic [7:0] sys_one_q; // standby, wait select, low speed
  logic [7:0] sys_two_q; // direct transfer, medium speed
  logic [7:0] timer_a_q; // watch timer select lives here
  logic [7:0] gate_one_q;
  logic [7:0] gate_two_q;
  logic [31:0] prdata_q;
  logic mapped; // address hits a register
  logic wr_en;

  // decode: every register is one aligned word
  always_comb begin
    unique case (paddr)
      OFF_SYS_ONE, OFF_SYS_TWO, OFF_TIMER_A, OFF_GATE_ONE, OFF_GATE_TWO,
      OFF_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states; unmapped access answers with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  // data sit in lane 0, so only that strobe writes
  assign wr_en = psel & penable & pwrite & pstrb[0] & mapped;

  // control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sys_one_q <= CTRL_RESET;
      sys_two_q <= CTRL_RESET;
      timer_a_q <= CTRL_RESET;
    end else if (wr_en) begin
      if (paddr == OFF_SYS_ONE) sys_one_q <= pwdata[7:0];
      if (paddr == OFF_SYS_TWO) sys_two_q <= pwdata[7:0];
      if (paddr == OFF_TIMER_A) timer_a_q <= pwdata[7:0];
    end
  end

  // clock stop registers: every module starts clocked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_one_q <= GATE_RESET;
      gate_two_q <= GATE_RESET;
    end else if (wr_en) begin
      // a 0 stops a module, a 1 restores it
      if (paddr == OFF_GATE_ONE) gate_one_q <= pwdata[7:0];
      if (paddr == OFF_GATE_TWO) gate_two_q <= pwdata[7:0];
    end
  end

  // read data captured in the setup cycle so it stands in the access cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFF_SYS_ONE: prdata_q <= {24'h00_0000, sys_one_q};
        OFF_SYS_TWO: prdata_q <= {24'h00_0000, sys_two_q};
        OFF_TIMER_A: prdata_q <= {24'h00_0000, timer_a_q};
        OFF_GATE_ONE: prdata_q <= {24'h00_0000, gate_one_q};
        OFF_GATE_TWO: prdata_q <= {24'h00_0000, gate_two_q};
        OFF_STATUS: prdata_q <= {22'h00_0000, cif.status};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_q;

  // fields to the controller
  assign cif.standby_select = sys_one_q[STANDBY_BIT];
  assign cif.standby_wait_select = sys_one_q[WAIT_SEL_LSB +: 3];
  assign cif.low_speed_on = sys_one_q[LOW_SPEED_BIT];
  assign cif.direct_transfer_on = sys_two_q[DIRECT_BIT];
  assign cif.medium_speed_on = sys_two_q[MEDIUM_BIT];
  assign cif.watch_timer_select = timer_a_q[WATCH_SEL_BIT];
  assign cif.module_clock_gate_one = gate_one_q;
  assign cif.module_clock_gate_two = gate_two_q;

  // both stop registers read all ones right after reset
  property p_gate_reset;
    @(posedge ref_clk) disable iff (rst)
    $past(rst) |-> (gate_one_q == GATE_RESET && gate_two_q == GATE_RESET);
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gate regs not all ones after reset");

  // a write of zeros to the first stop register lands on the next edge
  property p_gate_write;
    @(posedge ref_clk) disable iff (rst)
    (wr_en && paddr == OFF_GATE_ONE) |=> (gate_one_q == $past(pwdata[7:0]));
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate write not stored");
endmodule
`default_nettype wire

// *** core/clock_gate_bank.sv ***
// per-module clock enables and frozen interrupt requests
`default_nettype none
module clock_gate_bank
  import pwr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // gate registers
  ctrl_if.gates cif,
  // peripheral side
  input wire logic [N_GATED-1:0] irq_in,
  output logic [N_GATED-1:0] clk_en,
  output logic [N_GATED-1:0] irq_out
);
  logic [N_GATED-1:0] en_q; // enable for each module's clock gate cell
  logic [N_GATED-1:0] irq_q; // request as seen by the interrupt controller

  // registered enable keeps the gate cell free of glitches from the bus
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      en_q <= {N_GATED{1'b1}};
    end else begin
      en_q <= {cif.module_clock_gate_two[GATE_TWO_USED-1:0],
               cif.module_clock_gate_one[GATE_ONE_USED-1:0]};
    end
  end

  // a stopped module cannot withdraw its request, so it is held
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_q <= {N_GATED{1'b0}};
    end else begin
      for (int i = 0; i < N_GATED; i++) begin
        if (en_q[i]) irq_q[i] <= irq_in[i];
        else irq_q[i] <= irq_q[i];
      end
    end
  end

  assign clk_en = en_q;
  assign irq_out = irq_q;

  // a request outstanding at gating stays active while gated
  property p_irq_frozen;
    @(posedge ref_clk) disable iff (rst)
    (!en_q[0] && irq_q[0]) |=> irq_q[0];
  endproperty
  a_irq_frozen: assert property (p_irq_frozen) else $error("gated request dropped");

  // a one written back restores the clock one edge after the bit
  property p_gate_follow;
    @(posedge ref_clk) disable iff (rst)
    ##1 (en_q[GATE_ONE_USED] == $past(cif.module_clock_gate_two[0]));
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("clock enable not following");
endmodule
`default_nettype wire

// *** core/mode_ctrl.sv ***
// top of the power-mode controller: direct transfers and module clock gates
// Notes on behaviour
// - high speed sleep with medium set goes medium
// - medium speed sleep with medium clear goes high
// - subactive sleep, medium clear, goes high speed
// - subactive sleep, medium set, goes medium speed
// - three states old clock, fourteen new clock
// - from subactive: subclock states, then wait, exception
// - subactive transfers always pass through watch mode
// - stopped module loses its system clock
// - zero bit puts module into standby
// - one bit releases module, clock restored
// - both stop registers reset to all ones
// - first register gates seven listed modules
// - second register gates four listed modules
// - gated module's pending request stays frozen
// - direct transfer keeps running, then exception handling
// - disabled transfer interrupt means sleep or watch
`default_nettype none
module mode_ctrl
  import pwr_pkg::*;
#(
  parameter logic [7:0][15:0] WAIT_TABLE = {8{16'h2000}} // wait states per select
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic sleep_exec,
  input wire logic dt_irq_enable,
  input wire logic cpu_irq_mask,
  input wire logic wake_req,
  output logic [1:0] cur_mode,
  output logic cpu_run,
  output logic watch_active,
  output logic dt_exception,
  output logic transfer_done,
  // peripheral side
  input wire logic [N_GATED-1:0] module_irq_in,
  output logic [N_GATED-1:0] module_clk_en,
  output logic [N_GATED-1:0] module_irq_out
);
  ctrl_if cif ();

  state_type state_q, state_d; // controller state
  mode_type mode_q; // mode whose clock the cpu runs on
  mode_type src_q; // mode a transfer leaves
  mode_type tgt_q; // mode a transfer enters
  logic [15:0] wait_q; // wait states latched at sleep
  logic [15:0] div_cnt_q; // ref_clk cycles inside one state
  logic [15:0] st_cnt_q; // states inside the current phase
  logic [15:0] div_sel;
  logic [15:0] limit_sel;
  logic tick; // one state of the phase clock ends
  logic phase_end;
  logic run_q, watch_q, exc_q, done_q;
  logic sb, ls, ms, dt, ws;
  logic dt_valid; // register settings form a direct transfer
  mode_type dt_tgt;
  logic dt_ok; // transfer interrupt can be taken
  logic timed; // in a counted phase
  logic [15:0] pre_len_q, exc_len_q; // helpers for the checks

  apb_regs u_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cif(cif)
  );

  clock_gate_bank u_gates (
    .ref_clk(ref_clk),
    .rst(rst),
    .cif(cif),
    .irq_in(module_irq_in),
    .clk_en(module_clk_en),
    .irq_out(module_irq_out)
  );

  assign sb = cif.standby_select;
  assign ls = cif.low_speed_on;
  assign ms = cif.medium_speed_on;
  assign dt = cif.direct_transfer_on;
  assign ws = cif.watch_timer_select;
  // an i-bit mask would leave the cpu in a mode no interrupt clears
  assign dt_ok = dt_irq_enable & ~cpu_irq_mask;

  // which transfer the current settings ask for from the current mode
  always_comb begin
    dt_valid = 1'b0;
    dt_tgt = mode_q;
    unique case (mode_q)
      MODE_HIGH: begin
        if (!sb && !ls && ms && dt) begin
          dt_valid = 1'b1;
          dt_tgt = MODE_MED;
        end else if (sb && ls && dt && ws) begin
          dt_valid = 1'b1;
          dt_tgt = MODE_SUB;
        end
      end
      MODE_MED: begin
        if (!sb && !ls && !ms && dt) begin
          dt_valid = 1'b1;
          dt_tgt = MODE_HIGH;
        end else if (sb && ls && dt && ws) begin
          dt_valid = 1'b1;
          dt_tgt = MODE_SUB;
        end
      end
      MODE_SUB: begin
        if (sb && !ls && dt && ws) begin
          dt_valid = 1'b1;
          dt_tgt = ms ? MODE_MED : MODE_HIGH;
        end
      end
      default: begin
        dt_valid = 1'b0;
      end
    endcase
  end

  // phase clock: source clock before the switch, target clock after
  assign div_sel = (state_q == ST_PRE) ? div_of(src_q) : div_of(tgt_q);
  always_comb begin
    unique case (state_q)
      ST_PRE: limit_sel = PRE_STATES;
      ST_WATCH: limit_sel = (tgt_q == MODE_SUB) ? WATCH_PASS_STATES : wait_q;
      ST_EXC: limit_sel = EXC_STATES;
      default: limit_sel = 16'h0001;
    endcase
  end
  assign timed = (state_q == ST_PRE) || (state_q == ST_WATCH) || (state_q == ST_EXC);
  assign tick = timed && (div_cnt_q == div_sel - 16'h0001);
  assign phase_end = tick && (st_cnt_q == limit_sel - 16'h0001);

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_HIGH, ST_MED, ST_SUB: begin
        if (sleep_exec) begin
          if (dt_valid && dt_ok) state_d = ST_PRE;
          else if (sb) state_d = ST_WATCH_HALT;
          else state_d = ST_SLEEP_HALT;
        end
      end
      ST_PRE: begin
        if (phase_end) begin
          if (src_q == MODE_SUB || tgt_q == MODE_SUB) state_d = ST_WATCH;
          else state_d = ST_EXC;
        end
      end
      ST_WATCH: if (phase_end) state_d = ST_EXC;
      ST_EXC: begin
        if (phase_end) begin
          unique case (tgt_q)
            MODE_HIGH: state_d = ST_HIGH;
            MODE_MED: state_d = ST_MED;
            default: state_d = ST_SUB;
          endcase
        end
      end
      ST_SLEEP_HALT, ST_WATCH_HALT: begin
        if (wake_req) begin
          unique case (mode_q)
            MODE_HIGH: state_d = ST_HIGH;
            MODE_MED: state_d = ST_MED;
            default: state_d = ST_SUB;
          endcase
        end
      end
      default: state_d = ST_MED;
    endcase
  end

  // state register; reset lands in medium-speed active mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) state_q <= ST_MED;
    else state_q <= state_d;
  end

  // phase counters restart on every state change
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 16'h0000;
      st_cnt_q <= 16'h0000;
    end else if (!timed || phase_end) begin
      div_cnt_q <= 16'h0000;
      st_cnt_q <= 16'h0000;
    end else if (tick) begin
      div_cnt_q <= 16'h0000;
      st_cnt_q <= st_cnt_q + 16'h0001;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // transfer endpoints and wait latched when sleep is taken
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      src_q <= MODE_MED;
      tgt_q <= MODE_MED;
      wait_q <= 16'h0001;
    end else if (state_d == ST_PRE && state_q != ST_PRE) begin
      src_q <= mode_q;
      tgt_q <= dt_tgt;
      wait_q <= WAIT_TABLE[cif.standby_wait_select];
    end
  end

  // the cpu clock switches to the target once the old-clock states end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) mode_q <= MODE_MED;
    else if (state_q == ST_PRE && phase_end) mode_q <= tgt_q;
  end

  // cpu-facing levels and the completion pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b1;
      watch_q <= 1'b0;
      exc_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      // program execution only halts in watch or the halt modes
      run_q <= !(state_d == ST_WATCH || state_d == ST_SLEEP_HALT ||
                 state_d == ST_WATCH_HALT);
      // watch handling of inputs, as for standby-type transitions
      watch_q <= (state_d == ST_WATCH) || (state_d == ST_WATCH_HALT);
      exc_q <= (state_d == ST_EXC);
      done_q <= (state_q == ST_EXC) && phase_end;
    end
  end

  assign cur_mode = mode_q;
  assign cpu_run = run_q;
  assign watch_active = watch_q;
  assign dt_exception = exc_q;
  assign transfer_done = done_q;
  assign cif.status = {mode_q, state_q};

  // length counters that only the checks read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pre_len_q <= 16'h0000;
      exc_len_q <= 16'h0000;
    end else begin
      pre_len_q <= (state_q == ST_PRE) ? pre_len_q + 16'h0001 : 16'h0000;
      exc_len_q <= (state_q == ST_EXC) ? exc_len_q + 16'h0001 : 16'h0000;
    end
  end

  property p_high_to_med;
    @(posedge ref_clk) disable iff (rst)
    (state_q == ST_HIGH && sleep_exec && dt_ok && !sb && !ls && ms && dt)
      |=> (state_q == ST_PRE && tgt_q == MODE_MED);
  endproperty
  a_high_to_med: assert property (p_high_to_med) else $error("no transfer high to medium");

  property p_med_to_high;
    @(posedge ref_clk) disable iff (rst)
    (state_q == ST_MED && sleep_exec && dt_ok && !sb && !ls && !ms && dt)
      |=> (state_q == ST_PRE && tgt_q == MODE_HIGH);
  endproperty
  a_med_to_high: assert property (p_med_to_high) else $error("no transfer medium to high");

  property p_sub_to_high;
    @(posedge ref_clk) disable iff (rst)
    (state_q == ST_SUB && sleep_exec && dt_ok && sb && !ls && !ms && dt && ws)
      |=> (state_q == ST_PRE && tgt_q == MODE_HIGH);
  endproperty
  a_sub_to_high: assert property (p_sub_to_high) else $error("no transfer sub to high");

  property p_sub_to_med;
    @(posedge ref_clk) disable iff (rst)
    (state_q == ST_SUB && sleep_exec && dt_ok && sb && !ls && ms && dt && ws)
      |=> (state_q == ST_PRE && tgt_q == MODE_MED);
  endproperty
  a_sub_to_med: assert property (p_sub_to_med) else $error("no transfer sub to medium");

  property p_pre_high_len;
    @(posedge ref_clk) disable iff (rst)
    ($rose(state_q == ST_PRE) && src_q == MODE_HIGH)
      |-> (state_q == ST_PRE) [*6] ##1 (state_q != ST_PRE);
  endproperty
  a_pre_high_len: assert property (p_pre_high_len) else $error("pre states wrong length");

  property p_exc_len;
    @(posedge ref_clk) disable iff (rst)
    $fell(state_q == ST_EXC) |-> (exc_len_q == EXC_STATES * div_of(tgt_q));
  endproperty
  a_exc_len: assert property (p_exc_len) else $error("exception states wrong length");

  property p_pre_sub_len;
    @(posedge ref_clk) disable iff (rst)
    ($fell(state_q == ST_PRE) && src_q == MODE_SUB) |-> (pre_len_q == PRE_STATES * SUB_DIV);
  endproperty
  a_pre_sub_len: assert property (p_pre_sub_len) else $error("subclock states wrong length");

  property p_via_watch;
    @(posedge ref_clk) disable iff (rst)
    (state_q == ST_PRE && phase_end && (src_q == MODE_SUB || tgt_q == MODE_SUB))
      |=> (state_q == ST_WATCH) ##1 watch_active;
  endproperty
  a_via_watch: assert property (p_via_watch) else $error("sub transfer skipped watch");

  property p_end_mode;
    @(posedge ref_clk) disable iff (rst)
    $fell(state_q == ST_EXC) |-> (mode_q == tgt_q && transfer_done && cpu_run);
  endproperty
  a_end_mode: assert property (p_end_mode) else $error("transfer did not complete");

  property p_disabled_halts;
    @(posedge ref_clk) disable iff (rst)
    ((state_q == ST_HIGH || state_q == ST_MED) && sleep_exec && dt_valid && !dt_ok)
      |=> ((state_q == ST_SLEEP_HALT || state_q == ST_WATCH_HALT) && !cpu_run);
  endproperty
  a_disabled_halts: assert property (p_disabled_halts) else $error("no halt on masked transfer");
endmodule
`default_nettype wire

// *** verification/periph_model.sv ***
// request sources of the gated peripherals
`default_nettype none
module periph_model
  import pwr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // request pattern commanded by the bench
  input wire logic [N_GATED-1:0] raise,
  // requests toward the controller
  output logic [N_GATED-1:0] irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // sources keep moving while gated, so only the controller's freeze holds them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq <= '0;
    end else begin
      irq <= raise;
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the power-mode clock controller
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_top
  import pwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] WAIT_ST = 16'h0004; // shortened wait keeps the run short
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, g1, g2;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic sleep_exec, dt_irq_enable, cpu_irq_mask, wake_req, saw_w, saw_x;
  logic cpu_run, watch_active, dt_exception, transfer_done;
  logic [1:0] cur_mode;
  logic [N_GATED-1:0] raise, irq_in, clk_en, irq_out, r1, en;
  int num_errors, compares, n;
  mode_type cm; // mode the bench believes is current
  mode_type seq[6] = '{MODE_HIGH, MODE_MED, MODE_SUB, MODE_HIGH, MODE_SUB, MODE_MED};
  mode_ctrl #(.WAIT_TABLE({8{WAIT_ST}})) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .dt_irq_enable(dt_irq_enable), .cpu_irq_mask(cpu_irq_mask), .wake_req(wake_req),
    .cur_mode(cur_mode), .cpu_run(cpu_run), .watch_active(watch_active),
    .dt_exception(dt_exception), .transfer_done(transfer_done), .module_irq_in(irq_in),
    .module_clk_en(clk_en), .module_irq_out(irq_out));
  periph_model pm (.ref_clk(ref_clk), .rst(rst), .raise(raise), .irq(irq_in));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // state length in ref_clk cycles
  function automatic int dv(input mode_type m);
    return (m == MODE_HIGH) ? HIGH_DIV : (m == MODE_MED) ? MED_DIV : SUB_DIV;
  endfunction
  // edges from the sleep edge to the done pulse
  function automatic int etime(input mode_type s, input mode_type t);
    int w;
    w = (t == MODE_SUB) ? 1 : (s == MODE_SUB) ? WAIT_ST : 0;
    return 1 + PRE_STATES * dv(s) + (w + EXC_STATES) * dv(t);
  endfunction
  // one apb transfer; an idle edge follows so back to back calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // sleep pulse, then time the transfer up to the done pulse
  task automatic xfer(input mode_type s, input mode_type t);
    sleep_exec <= 1'b1;
    @(posedge ref_clk);
    sleep_exec <= 1'b0;
    n = 1;
    saw_w = 1'b0;
    saw_x = 1'b0;
    while (transfer_done !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1;
      n++;
      saw_w |= watch_active;
      saw_x |= dt_exception;
    end
    `CHK(n, etime(s, t))
    `CHK(cur_mode, t)
    `CHK(saw_w, s == MODE_SUB || t == MODE_SUB)
    `CHK(saw_x, 1'b1)
    @(posedge ref_clk);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a hang is cut short far beyond the expected run length
  initial begin
    #1000000;
    num_errors++;
    complete_run();
  end
  initial begin
    num_errors = 0;
    compares = 0;
    {rst, psel, penable, pwrite, sleep_exec, cpu_irq_mask, wake_req} = 7'h40;
    {paddr, pwdata, raise} = '0;
    pstrb = 4'hf;
    dt_irq_enable = 1'b1;
    void'($urandom(32'hc76a));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK(clk_en, {N_GATED{1'b1}})
    apb(1'b0, OFF_GATE_TWO, 8'h00);
    `CHK(rd[7:0], GATE_RESET)
    apb(1'b0, 8'h18, 8'h00);
    `CHK({err, rd}, {1'b1, 32'h0})
    // gate patterns: first register all stopped with no request, then timer_a stopped while
    // requesting so the freeze is exercised, random, second all running
    for (int i = 0; i < 4; i++) begin
      r1 = (i == 0) ? '0 : N_GATED'($urandom) | 11'h001;
      g1 = (i == 0) ? 8'h00 : (i == 1) ? 8'($urandom) & 8'hfe : 8'($urandom);
      g2 = (i == 3) ? 8'hff : 8'($urandom);
      en = {g2[3:0], g1[6:0]};
      raise <= r1;
      apb(1'b1, OFF_GATE_ONE, 8'hff);
      apb(1'b1, OFF_GATE_TWO, 8'hff);
      apb(1'b1, OFF_GATE_ONE, g1);
      apb(1'b1, OFF_GATE_TWO, g2);
      // the enable lags its stop bit by one edge
      @(posedge ref_clk);
      `CHK(clk_en, en)
      raise <= ~r1;
      repeat (3) @(posedge ref_clk);
      `CHK(irq_out, (r1 & ~en) | (~r1 & en))
      apb(1'b0, OFF_GATE_ONE, 8'h00);
      `CHK(rd[7:0], g1)
    end
    cm = MODE_MED;
    apb(1'b1, OFF_TIMER_A, 8'h08);
    foreach (seq[i]) begin
      apb(1'b1, OFF_SYS_ONE, {cm == MODE_SUB || seq[i] == MODE_SUB, 3'($urandom),
        seq[i] == MODE_SUB, 3'h0});
      apb(1'b1, OFF_SYS_TWO, {4'h0, 1'b1, seq[i] == MODE_MED, 2'h0});
      xfer(cm, seq[i]);
      cm = seq[i];
    end
    // masked, then disabled transfer interrupt: halt instead of a valid transfer
    // medium clear makes medium-to-high valid; standby and low speed make medium-to-sub valid
    apb(1'b1, OFF_SYS_TWO, 8'h08);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_SYS_ONE, k ? 8'h88 : 8'h00);
      cpu_irq_mask <= (k == 0);
      dt_irq_enable <= (k == 0);
      sleep_exec <= 1'b1;
      @(posedge ref_clk);
      sleep_exec <= 1'b0;
      apb(1'b0, OFF_STATUS, 8'h00);
      `CHK(rd[9:0], {2'h1, k ? 8'h80 : 8'h40})
      `CHK(cpu_run, 1'b0)
      wake_req <= 1'b1;
      @(posedge ref_clk);
      wake_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      `CHK({cpu_run, cur_mode}, 3'h5)
    end
    complete_run();
  end
endmodule
`default_nettype wire
